//--- core/span_fill_regs.svh
// register indices, field positions and reset values of the span fill engine
// assumes inclusion by the engine module only
`ifndef SPAN_FILL_REGS_SVH
`define SPAN_FILL_REGS_SVH

// --------------------------------------------------------------
// register word indices (byte address = index * 4)
// --------------------------------------------------------------
`define REG_PLANE    4'h8
`define REG_FILL     4'h9
`define REG_ROP      4'hA
`define REG_FG       4'hB
`define REG_BG       4'hC
`define REG_PIXGATE  4'hD
`define REG_MODE     4'hE
`define REG_STATUS   4'hF
`define FB_SEL_BIT   23

// --------------------------------------------------------------
// field positions
// --------------------------------------------------------------
`define CNT_MSB      10
`define LOWADR_LSB   16
`define LOWADR_MSB   17
`define ROP_MSB      3
`define DSTBM_LSB    8
`define DSTBM_MSB    9
`define DST_PACKED8  2'h1
`define MODE_OPAQUE  0
`define MODE_DEPTH32 1
`define ST_BUSY      0
`define ST_ERR       1
`define ST_SEG_LSB   8
`define ST_SEG_MSB   14

// --------------------------------------------------------------
// constants and reset values
// --------------------------------------------------------------
`define SEG_PIXELS   13'h0020
`define PLANE_RESET  32'hFFFFFFFF
`define AXI_OKAY     2'h0
`define AXI_SLVERR   2'h2
`endif

//--- core/span_fill_pkg.sv
// types of the span fill engine: state encoding and the state record
// assumes nothing beyond a SystemVerilog compiler
package span_fill_pkg;

  typedef enum logic [2:0] {
    IDLE = 3'h0,
    BLK1 = 3'h1,
    BLK2 = 3'h3,
    OPIX = 3'h2,
    ORD  = 3'h6,
    OWR  = 3'h7
  } fill_state_t;

  typedef struct packed {
    fill_state_t      st;
    logic [7:0][31:0] bcol;
    logic [31:0]      planeMask;
    logic [31:0]      fillMask;
    logic [11:0]      rop;
    logic [31:0]      fg;
    logic [31:0]      bg;
    logic [31:0]      pixGate;
    logic             opaque;
    logic             depth32;
    logic             errFlag;
    logic             awHave;
    logic             wHave;
    logic [23:0]      awAddr;
    logic [31:0]      wData;
    logic [3:0]       wStrb;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic [12:0]      rem;
    logic [23:0]      base;
    logic [1:0]       lo;
    logic [4:0]       k;
    logic [31:0]      fm;
    logic [6:0]       segCount;
    logic             issued;
    logic             vValid;
    logic             vWrite;
    logic             vBlock;
    logic [23:0]      vAddr;
    logic [31:0]      vData;
    logic [31:0]      vMask;
    logic [31:0]      vPlane;
    logic [255:0]     pat;
  } engine_state_t;

endpackage

//--- core/span_block_opaque_fill_engine.sv
// span fill engine: block-fill and opaque-fill of frame-buffer spans
// assumes an AXI4-Lite master and a frame-buffer memory port with
// valid/ready requests and read data returned a cycle or more later
//
// How it works
// RQ1: block mode: frame-buffer write starts a fill of up to 2K pixels
// RQ2: write data holds count-1 in bits 10:0, low address in 17:16
// RQ3: eight block colour words repeat four times across 32 pixels
// RQ4: mask bit 1 writes the pattern colour, bit 0 leaves pixel alone
// RQ5: fill mask latched once, reused for every 32-pixel segment
// RQ6: after each segment count drops by 32, address moves on
// RQ7: last partial segment masked to its remaining low mask bits
// RQ8: low start bits from write data allow unaligned byte bitmaps
// RQ9: block fill refused for packed byte bitmap in 32-bpp buffer
// RQ10: host loads block colours in the destination format first
// RQ11: block writes carry the plane write mask
// RQ12: opaque mode: same trigger and encoding, bitonal fill
// RQ13: opaque mode uses page-mode writes, never block writes
// RQ14: opaque: foreground where mask bit 1, background where 0
// RQ15: opaque: raster op bits 3:0 combine source with destination
// RQ16: opaque: pixel gate mask bit 0 leaves the pixel unmodified
// RQ17: opaque: 32-pixel pattern repeats over the whole count
// RQ18: host gives a start address aligned to one pixel
// RQ19: host pre-rotates both masks to a four-pixel boundary
// RQ20: one block cycle when 32-aligned, otherwise two in a row
// RQ21: hardware rotates the mask from 4- to 32-pixel alignment
// RQ22: block modes apply no raster op, pattern replaces pixel
// RQ23: writes are held off until the whole span is drawn
`timescale 1ns/100ps
`include "span_fill_regs.svh"

module span_block_opaque_fill_engine
  import span_fill_pkg::*;
(
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // axi4-lite slave
  input  wire logic         awvalid,
  output      logic         awready,
  input  wire logic [23:0]  awaddr,
  input  wire logic         wvalid,
  output      logic         wready,
  input  wire logic [31:0]  wdata,
  input  wire logic [3:0]   wstrb,
  output      logic         bvalid,
  input  wire logic         bready,
  output      logic [1:0]   bresp,
  input  wire logic         arvalid,
  output      logic         arready,
  input  wire logic [23:0]  araddr,
  output      logic         rvalid,
  input  wire logic         rready,
  output      logic [31:0]  rdata,
  output      logic [1:0]   rresp,
  // frame-buffer memory port
  output      logic         vramValid,
  input  wire logic         vramReady,
  output      logic         vramWrite,
  output      logic         vramBlock,
  output      logic [23:0]  vramAddr,
  output      logic [31:0]  vramData,
  output      logic [31:0]  vramPixMask,
  output      logic [31:0]  vramPlaneMask,
  output      logic [255:0] blockPattern,
  input  wire logic         vramRdValid,
  input  wire logic [31:0]  vramRdData
);

  engine_state_t q;
  engine_state_t n;
  logic          exec;
  logic          startFill;
  logic          reject;
  logic          segDone;
  logic          pixEn;
  logic          lastPix;
  logic [22:0]   startPix;
  logic [31:0]   segMask;
  logic [63:0]   seg64;
  logic [31:0]   srcCol;
  logic [31:0]   ropOut;

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // pixels from lo up to rem-1 of the current 32-pixel segment
  function automatic logic [31:0] rangeMask(input logic [12:0] rem,
                                            input logic [1:0]  lo);
    logic [31:0] hi;
    hi = (rem >= `SEG_PIXELS) ? 32'hFFFFFFFF
                              : ((32'h1 << rem[4:0]) - 32'h1);
    return hi & ~((32'h1 << lo) - 32'h1);
  endfunction

  function automatic logic [31:0] rasterOp(input logic [3:0]  r,
                                           input logic [31:0] s,
                                           input logic [31:0] d);
    return ({32{r[0]}} & s & d) | ({32{r[1]}} & s & ~d) |
           ({32{r[2]}} & ~s & d) | ({32{r[3]}} & ~s & ~d);
  endfunction

  function automatic logic [33:0] readMux(input logic [23:0] a);
    logic [31:0] d;
    logic [1:0]  r;
    d = 32'h0;
    r = `AXI_OKAY;
    if (a[`FB_SEL_BIT] || a[22:6] != 17'h0) begin
      r = `AXI_SLVERR;
    end else if (!a[5]) begin
      d = q.bcol[a[4:2]];
    end else begin
      unique case (a[5:2])
        `REG_PLANE:   d = q.planeMask;
        `REG_FILL:    d = q.fillMask;
        `REG_ROP:     d = {20'h0, q.rop};
        `REG_FG:      d = q.fg;
        `REG_BG:      d = q.bg;
        `REG_PIXGATE: d = q.pixGate;
        `REG_MODE:    d = {30'h0, q.depth32, q.opaque};
        default: begin
          d[`ST_BUSY] = (q.st != IDLE);
          d[`ST_ERR] = q.errFlag;
          d[`ST_SEG_MSB:`ST_SEG_LSB] = q.segCount;
        end
      endcase
    end
    return {r, d};
  endfunction

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    n = q;
    segDone = 1'b0;
    exec = q.awHave && q.wHave && !q.bvalid;
    startFill = exec && q.awAddr[`FB_SEL_BIT];
    reject = !q.opaque && q.depth32 &&
             q.rop[`DSTBM_MSB:`DSTBM_LSB] == `DST_PACKED8;
    startPix = q.depth32 ? {2'h0, q.awAddr[22:2]}
                         : {q.awAddr[22:2],
                            q.wData[`LOWADR_MSB:`LOWADR_LSB]}; // RQ8
    segMask = q.fm & rangeMask(q.rem, q.lo); // RQ4 RQ7
    seg64 = {32'h0, segMask} << {q.base[4:2], 2'b00}; // RQ21
    pixEn = ({3'h0, q.k} >= {3'h0, q.lo}) &&
            ({8'h0, q.k} < q.rem) && q.pixGate[q.k]; // RQ16
    lastPix = (q.k == 5'h1F) || ({8'h0, q.k} + 13'h1 >= q.rem);
    srcCol = q.fm[q.k] ? q.fg : q.bg; // RQ14
    ropOut = rasterOp(q.rop[`ROP_MSB:0], srcCol, vramRdData); // RQ15

    if (q.vValid && vramReady) begin
      n.vValid = 1'b0;
    end
    if (q.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (q.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (arvalid && q.arready) begin
      n.rvalid = 1'b1;
      {n.rresp, n.rdata} = readMux(araddr);
    end
    if (awvalid && q.awready) begin
      n.awHave = 1'b1;
      n.awAddr = awaddr;
    end
    if (wvalid && q.wready) begin
      n.wHave = 1'b1;
      n.wData = wdata;
      n.wStrb = wstrb;
    end

    // ------------------------------------------------------------
    // write execution: register update or fill start
    // ------------------------------------------------------------
    if (exec) begin
      n.awHave = 1'b0;
      n.wHave = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `AXI_OKAY;
      if (startFill) begin
        if (reject) begin
          n.errFlag = 1'b1; // RQ9
        end else begin
          n.base = {1'b0, startPix[22:2], 2'b00}; // RQ1 RQ12
          n.lo = startPix[1:0];
          n.rem = 13'(q.wData[`CNT_MSB:0]) + 13'h1 +
                  {11'h0, startPix[1:0]}; // RQ2
          n.fm = q.fillMask; // RQ5
          n.k = 5'h0;
          n.segCount = 7'h0;
          n.issued = 1'b0;
          n.st = q.opaque ? OPIX : BLK1;
        end
      end else if (q.awAddr[22:6] != 17'h0) begin
        n.bresp = `AXI_SLVERR;
      end else if (!q.awAddr[5]) begin
        n.bcol[q.awAddr[4:2]] = merge(q.bcol[q.awAddr[4:2]], q.wData,
                                      q.wStrb);
      end else begin
        unique case (q.awAddr[5:2])
          `REG_PLANE:   n.planeMask = merge(q.planeMask, q.wData, q.wStrb);
          `REG_FILL:    n.fillMask = merge(q.fillMask, q.wData, q.wStrb);
          `REG_ROP:     n.rop = 12'(merge({20'h0, q.rop}, q.wData,
                                          q.wStrb));
          `REG_FG:      n.fg = merge(q.fg, q.wData, q.wStrb);
          `REG_BG:      n.bg = merge(q.bg, q.wData, q.wStrb);
          `REG_PIXGATE: n.pixGate = merge(q.pixGate, q.wData, q.wStrb);
          `REG_MODE: begin
            if (q.wStrb[0]) begin
              n.opaque = q.wData[`MODE_OPAQUE];
              n.depth32 = q.wData[`MODE_DEPTH32];
            end
          end
          default: begin
            if (q.wStrb[0] && q.wData[`ST_ERR]) begin
              n.errFlag = 1'b0;
            end
          end
        endcase
      end
    end

    // ------------------------------------------------------------
    // drawing engine
    // ------------------------------------------------------------
    unique case (q.st)
      IDLE: begin
      end
      BLK1: begin
        if (!q.issued) begin
          n.issued = 1'b1;
          n.vValid = 1'b1;
          n.vWrite = 1'b1;
          n.vBlock = 1'b1; // RQ20
          n.vAddr = {q.base[23:5], 5'h0};
          n.vMask = seg64[31:0];
          n.vPlane = q.planeMask; // RQ11
          n.pat = q.bcol; // RQ3 RQ22
        end else if (q.vValid && vramReady) begin
          n.issued = 1'b0;
          if (q.base[4:0] != 5'h0) begin
            n.st = BLK2; // RQ20
          end else begin
            segDone = 1'b1;
          end
        end
      end
      BLK2: begin
        if (!q.issued) begin
          n.issued = 1'b1;
          n.vValid = 1'b1;
          n.vAddr = {q.base[23:5] + 19'h1, 5'h0};
          n.vMask = seg64[63:32]; // RQ21
        end else if (q.vValid && vramReady) begin
          n.issued = 1'b0;
          segDone = 1'b1;
        end
      end
      OPIX: begin
        if (!pixEn) begin
          if (lastPix) begin
            segDone = 1'b1;
          end else begin
            n.k = q.k + 5'h1;
          end
        end else begin
          n.vValid = 1'b1;
          n.vWrite = 1'b0;
          n.vBlock = 1'b0; // RQ13
          n.vAddr = q.base + {19'h0, q.k};
          n.vMask = 32'h1;
          n.vPlane = q.planeMask;
          n.st = ORD;
        end
      end
      ORD: begin
        if (vramRdValid && !q.vValid) begin
          n.vValid = 1'b1;
          n.vWrite = 1'b1;
          n.vData = (ropOut & q.planeMask) |
                    (vramRdData & ~q.planeMask); // RQ15
          n.st = OWR;
        end
      end
      OWR: begin
        if (q.vValid && vramReady) begin
          if (lastPix) begin
            segDone = 1'b1;
          end else begin
            n.k = q.k + 5'h1;
            n.st = OPIX;
          end
        end
      end
      default: begin
        n.st = IDLE;
      end
    endcase

    if (segDone) begin
      n.k = 5'h0;
      if (q.rem <= `SEG_PIXELS) begin
        n.st = IDLE;
      end else begin
        n.rem = q.rem - `SEG_PIXELS; // RQ6
        n.base = q.base + 24'h20;
        n.lo = 2'h0;
        n.segCount = q.segCount + 7'h1;
        n.st = q.opaque ? OPIX : BLK1; // RQ17
      end
    end

    n.awready = (n.st == IDLE) && !n.awHave && !n.bvalid; // RQ23
    n.wready = (n.st == IDLE) && !n.wHave && !n.bvalid; // RQ23
    n.arready = !n.rvalid;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.planeMask <= `PLANE_RESET;
    end else begin
      q <= n;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign vramValid = q.vValid;
  assign vramWrite = q.vWrite;
  assign vramBlock = q.vBlock;
  assign vramAddr = q.vAddr;
  assign vramData = q.vData;
  assign vramPixMask = q.vMask;
  assign vramPlaneMask = q.vPlane;
  assign blockPattern = q.pat;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_holdoff_busy: assert property ( // RQ23
    q.st != IDLE |-> !awready && !wready)
    else $error("write accepted while drawing");
  chk_split_seg: assert property ( // RQ20
    q.st == BLK1 && q.issued && q.vValid && vramReady &&
    q.base[4:0] != 5'h0 |=> q.st == BLK2 ##1 vramValid && vramBlock)
    else $error("unaligned segment not split in two");
  chk_opaque_page: assert property ( // RQ13
    vramValid && q.opaque && q.st != IDLE |-> !vramBlock)
    else $error("block cycle in opaque mode");
  chk_plane_gate: assert property ( // RQ11
    vramValid && vramBlock |-> vramPlaneMask == q.planeMask)
    else $error("plane mask not on block write");
  chk_seg_step: assert property ( // RQ6
    $past(q.st) != IDLE && q.segCount != $past(q.segCount) |->
    q.rem == $past(q.rem) - `SEG_PIXELS)
    else $error("segment count step wrong");
  chk_reject_packed: assert property ( // RQ9
    startFill && reject |=> q.st == IDLE && q.errFlag)
    else $error("packed byte fill in 32-bpp not refused");
  chk_gate_pixel: assert property ( // RQ16
    q.st == OPIX ##1 q.st == ORD |-> q.pixGate[q.k])
    else $error("gated pixel was accessed");
  chk_last_seg: assert property ( // RQ7
    q.st == BLK1 && vramValid && q.base[4:0] == 5'h0 &&
    q.rem < `SEG_PIXELS |-> (vramPixMask >> q.rem[4:0]) == 32'h0)
    else $error("pixels beyond count enabled");
  chk_opaque_colour: assert property ( // RQ14
    q.st == ORD ##1 q.st == OWR && q.rop[3:0] == 4'h3 |->
    vramData == (((q.fm[q.k] ? q.fg : q.bg) & q.planeMask) |
                 ($past(vramRdData) & ~q.planeMask)))
    else $error("opaque colour choice wrong");
  chk_count_load: assert property ( // RQ2
    startFill && !reject |=> q.rem == 13'($past(q.wData[10:0])) +
    13'h1 + {11'h0, q.lo})
    else $error("pixel count not loaded");

  cov_split: cover property (q.st == BLK2 && vramValid && vramReady);
  cov_opaque: cover property (q.st == OWR && vramValid && vramReady);
  cov_multi: cover property (q.segCount == 7'h2 && q.st == BLK1);
  cov_reject: cover property (startFill && reject);

endmodule

//--- testbench/vram_model.sv
// frame-buffer memory model: accepts requests, answers reads, logs writes
// assumes the engine's valid/ready memory port and a single clock
`timescale 1ns/100ps
module vram_model (
  // clock, reset and pace
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [3:0]   lag,
  // memory port
  input  wire logic         vramValid,
  output      logic         vramReady,
  input  wire logic         vramWrite,
  input  wire logic         vramBlock,
  input  wire logic [23:0]  vramAddr,
  input  wire logic [31:0]  vramData,
  input  wire logic [31:0]  vramPixMask,
  input  wire logic [31:0]  vramPlaneMask,
  input  wire logic [255:0] blockPattern,
  output      logic         vramRdValid,
  output      logic [31:0]  vramRdData
);
  logic [23:0]  addrQ[$];
  logic [31:0]  dataQ[$];
  logic         blkQ[$];
  logic [255:0] lastPat;
  logic [31:0]  lastPlane;
  logic [23:0]  rdAddr;
  int           waitCnt;
  int           rdCnt;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      vramReady   <= 1'b0;
      vramRdValid <= 1'b0;
      vramRdData  <= 32'h0;
      waitCnt     <= 0;
      rdCnt       <= 0;
    end else begin
      vramRdValid <= 1'b0;
      // stale read data inverts every cycle
      vramRdData  <= ~vramRdData;
      if (rdCnt == 1) begin
        vramRdValid <= 1'b1;
        vramRdData  <= {8'h5A, rdAddr};
      end
      if (rdCnt > 0)
        rdCnt <= rdCnt - 1;
      if (vramValid && vramReady) begin
        vramReady <= 1'b0;
        waitCnt   <= 0;
        if (vramWrite) begin
          addrQ.push_back(vramAddr);
          dataQ.push_back(vramBlock ? vramPixMask : vramData);
          blkQ.push_back(vramBlock);
          lastPat   <= blockPattern;
          lastPlane <= vramPlaneMask;
        end else begin
          rdAddr <= vramAddr;
          rdCnt  <= lag + 1;
        end
      end else if (vramValid) begin
        vramReady <= (waitCnt >= lag);
        waitCnt   <= waitCnt + 1;
      end
    end
  end
endmodule

//--- testbench/span_block_opaque_fill_engine_tb.sv
// self-checking bench of the span fill engine
// assumes the memory model in vram_model.sv and a 250 MHz clock
`timescale 1ns/100ps
module span_block_opaque_fill_engine_tb;
  logic         clock, rst_n, awvalid, awready, wvalid, wready, bvalid;
  logic         bready, arvalid, arready, rvalid, rready;
  logic         vramValid, vramReady, vramWrite, vramBlock, vramRdValid;
  logic [23:0]  awaddr, araddr, vramAddr;
  logic [31:0]  wdata, rdata, vramData, vramPixMask, vramPlaneMask;
  logic [31:0]  vramRdData, rd;
  logic [3:0]   wstrb, lag;
  logic [1:0]   bresp, rresp, resp;
  logic [255:0] blockPattern, pat;
  logic         d32;
  int           mismatches, checks, cycles;

  span_block_opaque_fill_engine span_block_opaque_fill_engine_i (
    .clock, .rst_n, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready, .rdata, .rresp, .vramValid, .vramReady, .vramWrite, .vramBlock,
    .vramAddr, .vramData, .vramPixMask, .vramPlaneMask, .blockPattern,
    .vramRdValid, .vramRdData);

  vram_model vram_model_i (
    .clock, .rst_n, .lag, .vramValid, .vramReady, .vramWrite, .vramBlock,
    .vramAddr, .vramData, .vramPixMask, .vramPlaneMask, .blockPattern,
    .vramRdValid, .vramRdData);

  // ----------------------------------------------------------
  // compare, bus cycles
  // ----------------------------------------------------------
  task automatic check(string what, logic [255:0] seen, logic [255:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 1'b0;
    w  = 1'b0;
    @(posedge clock);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clock);
      if (awvalid && awready === 1'b1) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1)
      @(posedge clock);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [23:0] a);
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clock); while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic fb(logic [20:0] word, logic [1:0] lo, logic [10:0] cnt1);
    wr(24'h80_0000 | {word, 2'b00}, {14'h0, lo, 5'h0, cnt1});
  endtask

  task automatic wait_idle;
    do rd_reg(24'h3C); while (rd[0] !== 1'b0);
  endtask

  task automatic pop(logic [23:0] a, logic [31:0] d, logic b);
    if (vram_model_i.addrQ.size() == 0) begin
      check("write present", 0, 1);
      return;
    end
    check("write addr", vram_model_i.addrQ.pop_front(), a);
    check("write data", vram_model_i.dataQ.pop_front(), d);
    check("write kind", vram_model_i.blkQ.pop_front(), b);
  endtask

  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_regs;
    rd_reg(24'h20);
    check("plane reset", rd, 32'hFFFF_FFFF);
    rd_reg(24'h3C);
    check("status reset", rd, 32'h0);
    rd_reg(24'h40);
    check("unmapped read", {resp, rd}, {2'h2, 32'h0});
    wr(24'h40, 32'h1);
    check("unmapped write", resp, 2'h2);
    rd_reg(24'h80_0000);
    check("window read", resp, 2'h2);
    $display("test registers done");
  endtask

  task automatic blk(logic [20:0] word, logic [1:0] lo, logic [10:0] cnt1,
                     logic [31:0] fm);
    int base;
    int rem;
    logic [63:0] m;
    logic [31:0] seg;
    wr(24'h24, fm);
    fb(word, lo, cnt1);
    check("start resp", resp, 2'h0);
    if (lag != 0) begin
      rd_reg(24'h3C);
      check("busy", rd[0], 1'b1);
      wr(24'h24, ~fm);
      rd_reg(24'h3C);
      check("held off", rd[0], 1'b0);
    end
    wait_idle;
    base = word * 4;
    if (d32) begin
      // 32-bpp: start pixel is the word, write-data low bits ignored
      lo = word[1:0];
      base = word - lo;
    end
    rem = cnt1 + 1 + lo;
    for (int s = 0; s * 32 < rem; s++) begin
      seg = fm;
      for (int i = 0; i < 32; i++)
        if ((s == 0 && i < lo) || s * 32 + i >= rem) seg[i] = 1'b0;
      m = {32'h0, seg} << (base % 32);
      pop(24'(base - base % 32), m[31:0], 1'b1);
      if (base % 32 != 0)
        pop(24'(base - base % 32 + 32), m[63:32], 1'b1);
      base += 32;
    end
    check("leftover", vram_model_i.addrQ.size(), 0);
    check("pattern", vram_model_i.lastPat, pat);
    check("plane", vram_model_i.lastPlane, 32'h00FF_FF00);
    $display("test block fill done");
  endtask

  task automatic t_refuse;
    wr(24'h38, 32'h2);
    d32 = 1'b1;
    blk(21'h43, 2'h3, 11'h00C, 32'hF00F_0FF0);
    d32 = 1'b0;
    wr(24'h28, 32'h100);
    fb(21'h10, 2'h0, 11'h1F);
    check("refused resp", resp, 2'h0);
    rd_reg(24'h3C);
    check("error flag", rd[1:0], 2'h2);
    wr(24'h3C, 32'h2);
    rd_reg(24'h3C);
    check("error clear", rd[1:0], 2'h0);
    check("no draw", vram_model_i.addrQ.size(), 0);
    wr(24'h28, 32'h0);
    wr(24'h38, 32'h1);
    $display("test refused fill done");
  endtask

  task automatic opq(logic [3:0] op);
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] res;
    wr(24'h28, {28'h0, op});
    fb(21'h2, 2'h2, 11'h3);
    wait_idle;
    for (int k = 2; k < 6; k++) begin
      // gate bit 3 is clear
      if (k == 3)
        continue;
      src = (k == 2) ? 32'hF0F0_1234 : 32'h0F0F_ABCD;
      dst = {8'h5A, 24'(8 + k)};
      for (int i = 0; i < 32; i++)
        res[i] = op[{~src[i], ~dst[i]}];
      pop(24'(8 + k), (res & 32'h00FF_FF00) | (dst & 32'hFF00_00FF),
          1'b0);
    end
    check("leftover", vram_model_i.addrQ.size(), 0);
  endtask

  // ----------------------------------------------------------
  // run control
  // ----------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      final_report;
    end
  end

  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, lag, d32} = '0;
    wstrb = 4'hF;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    t_regs;
    for (int j = 0; j < 8; j++) begin
      pat[32 * j +: 32] = 32'(32'h1111_1111 * (j + 1));
      wr(24'(4 * j), pat[32 * j +: 32]);
    end
    wr(24'h20, 32'h00FF_FF00);
    blk(21'h8, 2'h0, 11'h7FF, 32'hFFFF_FFFF);
    lag <= 4'h6;
    blk(21'h1, 2'h1, 11'h027, 32'h9F3C_A5E1);
    lag <= 4'h1;
    t_refuse;
    wr(24'h24, 32'h0000_0005);
    wr(24'h2C, 32'hF0F0_1234);
    wr(24'h30, 32'h0F0F_ABCD);
    wr(24'h34, 32'hFFFF_FFF7);
    for (int r = 0; r < 16; r++)
      opq(4'(r));
    $display("test opaque fill done");
    final_report;
  end
endmodule
